// *** rtl/uivt_pkg.sv ***
package uivt_pkg;

   // Register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Event sources, one status bit each, ordered by priority
   localparam int NUM_SRC = 17;
   localparam int SRC_W = 5;
   localparam int VEC_W = 8;
   localparam int PRIO_W = 5;
   localparam int ERR_CNT_W = 8;

   // Register offsets (word index on the plain port)
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h1;
   localparam logic [3:0] REG_VECTOR = 4'h2;
   localparam logic [3:0] REG_ERR_LIMIT = 4'h3;
   localparam logic [3:0] REG_ERR_COUNT = 4'h4;
   // Bit 16 of status and mask, in bit 0 of these words
   localparam logic [3:0] REG_STATUS_HI = 4'h5;
   localparam logic [3:0] REG_MASK_HI = 4'h6;

   // Reset values
   localparam logic [16:0] STATUS_RST = 17'h00000;
   localparam logic [16:0] MASK_RST = 17'h00000;
   localparam logic [7:0] ERR_LIMIT_RST = 8'h04;
   localparam logic [7:0] ERR_COUNT_RST = 8'h00;
   localparam logic [7:0] ERR_COUNT_MAX = 8'hFF;
   localparam logic [7:0] VEC_IDLE = 8'h00;
   localparam logic [4:0] SRC_IDX_RST = 5'h00;

   // Status bit positions
   localparam int SRC_CTRL_ACK = 0;
   localparam int SRC_EP1_OUT = 1;
   localparam int SRC_EP2 = 2;
   localparam int SRC_EP4 = 3;
   localparam int SRC_EP6 = 4;
   localparam int SRC_EP8 = 5;
   localparam int SRC_BULK_NAK = 6;
   localparam int SRC_PING0 = 7;
   localparam int SRC_PING1 = 8;
   localparam int SRC_PING2 = 9;
   localparam int SRC_PING4 = 10;
   localparam int SRC_PING6 = 11;
   localparam int SRC_PING8 = 12;
   localparam int SRC_ERR_LIM = 13;
   localparam int SRC_ISO2 = 14;
   localparam int SRC_ISO4 = 15;
   localparam int SRC_ISO6 = 16;

   // Priority numbers per source
   localparam logic [4:0] PRIO_CTRL_ACK = 5'h07;
   localparam logic [4:0] PRIO_EP1_OUT = 5'h0C;
   localparam logic [4:0] PRIO_EP2 = 5'h0D;
   localparam logic [4:0] PRIO_EP4 = 5'h0E;
   localparam logic [4:0] PRIO_EP6 = 5'h0F;
   localparam logic [4:0] PRIO_EP8 = 5'h10;
   localparam logic [4:0] PRIO_BULK_NAK = 5'h11;
   localparam logic [4:0] PRIO_PING0 = 5'h13;
   localparam logic [4:0] PRIO_PING1 = 5'h14;
   localparam logic [4:0] PRIO_PING2 = 5'h15;
   localparam logic [4:0] PRIO_PING4 = 5'h16;
   localparam logic [4:0] PRIO_PING6 = 5'h17;
   localparam logic [4:0] PRIO_PING8 = 5'h18;
   localparam logic [4:0] PRIO_ERR_LIM = 5'h19;
   localparam logic [4:0] PRIO_ISO2 = 5'h1D;
   localparam logic [4:0] PRIO_ISO4 = 5'h1E;
   localparam logic [4:0] PRIO_ISO6 = 5'h1F;

   // Vector offset is four times (priority minus one)
   localparam logic [4:0] PRIO_BIAS = 5'h01;

   function automatic logic [4:0] prio_of(input logic [4:0] idx);
      case (idx)
         5'h00: prio_of = PRIO_CTRL_ACK;
         5'h01: prio_of = PRIO_EP1_OUT;
         5'h02: prio_of = PRIO_EP2;
         5'h03: prio_of = PRIO_EP4;
         5'h04: prio_of = PRIO_EP6;
         5'h05: prio_of = PRIO_EP8;
         5'h06: prio_of = PRIO_BULK_NAK;
         5'h07: prio_of = PRIO_PING0;
         5'h08: prio_of = PRIO_PING1;
         5'h09: prio_of = PRIO_PING2;
         5'h0A: prio_of = PRIO_PING4;
         5'h0B: prio_of = PRIO_PING6;
         5'h0C: prio_of = PRIO_PING8;
         5'h0D: prio_of = PRIO_ERR_LIM;
         5'h0E: prio_of = PRIO_ISO2;
         5'h0F: prio_of = PRIO_ISO4;
         default: prio_of = PRIO_ISO6;
      endcase
   endfunction

   function automatic logic [7:0] vector_of(input logic [4:0] idx);
      logic [4:0] p;
      p = prio_of(idx) - PRIO_BIAS;
      vector_of = {1'b0, p, 2'b00};
   endfunction

endpackage

// *** rtl/uivt_sel_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface uivt_sel_if;
   logic [16:0] pending;
   logic found;
   logic [4:0] index;
   modport enc (input pending, output found, output index);
   modport ctl (output pending, input found, input index);
endinterface
`default_nettype wire

// *** rtl/uivt_prio_enc.sv ***
`timescale 1ns/10ps
`default_nettype none
module uivt_prio_enc (
   uivt_sel_if.enc sel
);

   // Lowest set bit, which carries the lowest priority number
   function automatic logic [4:0] first_set(input logic [16:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 16; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      first_set = r;
   endfunction

   assign sel.found = |sel.pending;
   assign sel.index = first_set(sel.pending);

endmodule
`default_nettype wire

// *** rtl/uivt_top.sv ***
// Notes on behaviour
// (RULE1) EP1 OUT data: priority 12, vector 2C
// (RULE2) EP2/4/6/8 buffers: vectors 30 to 3C
// (RULE3) Any IN NAK: priority 17, vector 40
// (RULE4) EP0 OUT ping NAK: vector 48
// (RULE5) EP1 OUT ping NAK: vector 4C
// (RULE6) EP2 OUT ping NAK: vector 50
// (RULE7) EP4 OUT ping NAK: vector 54
// (RULE8) EP6 OUT ping NAK: vector 58
// (RULE9) EP8 OUT ping NAK: vector 5C
// (RULE10) Bus errors beyond limit: vector 60
// (RULE11) Offsets 44, 64, 68, 6C never produced
// (RULE12) ISO EP2 PID error: vector 70
// (RULE13) ISO EP4 PID error: vector 74
// (RULE14) ISO EP6 PID error: vector 78
// (RULE15) Control handshake ACK: priority 7, vector 18
// (RULE16) Lowest priority number pending wins
// (RULE17) Pending until cleared, then next vector
`timescale 1ns/10ps
`default_nettype none
module uivt_top (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [15:0] RDATA,
   input wire logic CTRL_HANDSHAKE_ACK_IRQ,
   input wire logic EP_ONE_OUT_DATA_IRQ,
   input wire logic EP_TWO_BUF_IRQ,
   input wire logic EP_FOUR_BUF_IRQ,
   input wire logic EP_SIX_BUF_IRQ,
   input wire logic EP_EIGHT_BUF_IRQ,
   input wire logic BULK_IN_NAK_IRQ,
   input wire logic CTRL_OUT_PING_NAK_IRQ,
   input wire logic EP_ONE_OUT_PING_NAK_IRQ,
   input wire logic EP_TWO_OUT_PING_NAK_IRQ,
   input wire logic EP_FOUR_OUT_PING_NAK_IRQ,
   input wire logic EP_SIX_OUT_PING_NAK_IRQ,
   input wire logic EP_EIGHT_OUT_PING_NAK_IRQ,
   input wire logic BUS_ERROR,
   input wire logic ISO_TWO_PID_SEQ_IRQ,
   input wire logic ISO_FOUR_PID_SEQ_IRQ,
   input wire logic ISO_SIX_PID_SEQ_IRQ,
   input wire logic VECTOR_ACK,
   output logic IRQ,
   output logic VECTOR_VALID,
   output logic [7:0] IRQ_VECTOR
);

   logic [16:0] status_q;
   logic [16:0] status_d;
   logic [16:0] mask_q;
   logic [7:0] err_limit_q;
   logic [7:0] err_cnt_q;
   logic [7:0] err_cnt_d;
   logic [7:0] vec_q;
   logic [4:0] idx_q;
   logic valid_q;
   logic irq_q;
   logic [15:0] rdata_q;

   uivt_sel_if sel ();

   uivt_prio_enc u_enc (
      .sel(sel.enc)
   );

   // Address decode
   wire hit_status = ADDR == uivt_pkg::REG_STATUS;
   wire hit_mask = ADDR == uivt_pkg::REG_MASK;
   wire hit_vector = ADDR == uivt_pkg::REG_VECTOR;
   wire hit_limit = ADDR == uivt_pkg::REG_ERR_LIMIT;
   wire hit_count = ADDR == uivt_pkg::REG_ERR_COUNT;
   wire hit_status_hi = ADDR == uivt_pkg::REG_STATUS_HI;
   wire hit_mask_hi = ADDR == uivt_pkg::REG_MASK_HI;
   wire wr_status = WR_STB && hit_status;
   wire wr_mask = WR_STB && hit_mask;
   wire wr_status_hi = WR_STB && hit_status_hi;
   wire wr_mask_hi = WR_STB && hit_mask_hi;
   wire wr_limit = WR_STB && hit_limit;
   wire wr_count = WR_STB && hit_count;

   // Error counter: write clears, a coincident error still counts
   wire [7:0] err_base = wr_count ? uivt_pkg::ERR_COUNT_RST : err_cnt_q;
   wire err_sat = err_base == uivt_pkg::ERR_COUNT_MAX;
   wire err_inc = BUS_ERROR && !err_sat;
   // (RULE10) Threshold crossing event
   wire err_over = err_inc && (err_base == err_limit_q);

   assign err_cnt_d = err_inc ? 8'(err_base + 8'h01) : err_base;

   // Event vector in priority order
   wire [16:0] events;
   // (RULE15) Control handshake source
   assign events[uivt_pkg::SRC_CTRL_ACK] = CTRL_HANDSHAKE_ACK_IRQ;
   // (RULE1) Endpoint one OUT data
   assign events[uivt_pkg::SRC_EP1_OUT] = EP_ONE_OUT_DATA_IRQ;
   // (RULE2) Buffer sources
   assign events[uivt_pkg::SRC_EP2] = EP_TWO_BUF_IRQ;
   assign events[uivt_pkg::SRC_EP4] = EP_FOUR_BUF_IRQ;
   assign events[uivt_pkg::SRC_EP6] = EP_SIX_BUF_IRQ;
   assign events[uivt_pkg::SRC_EP8] = EP_EIGHT_BUF_IRQ;
   // (RULE3) Any IN endpoint NAK
   assign events[uivt_pkg::SRC_BULK_NAK] = BULK_IN_NAK_IRQ;
   // (RULE4) Ping NAK endpoint zero
   assign events[uivt_pkg::SRC_PING0] = CTRL_OUT_PING_NAK_IRQ;
   // (RULE5) Ping NAK endpoint one
   assign events[uivt_pkg::SRC_PING1] = EP_ONE_OUT_PING_NAK_IRQ;
   // (RULE6) Ping NAK endpoint two
   assign events[uivt_pkg::SRC_PING2] = EP_TWO_OUT_PING_NAK_IRQ;
   // (RULE7) Ping NAK endpoint four
   assign events[uivt_pkg::SRC_PING4] = EP_FOUR_OUT_PING_NAK_IRQ;
   // (RULE8) Ping NAK endpoint six
   assign events[uivt_pkg::SRC_PING6] = EP_SIX_OUT_PING_NAK_IRQ;
   // (RULE9) Ping NAK endpoint eight
   assign events[uivt_pkg::SRC_PING8] = EP_EIGHT_OUT_PING_NAK_IRQ;
   // (RULE10) Error limit source
   assign events[uivt_pkg::SRC_ERR_LIM] = err_over;
   // (RULE12) ISO two PID error
   assign events[uivt_pkg::SRC_ISO2] = ISO_TWO_PID_SEQ_IRQ;
   // (RULE13) ISO four PID error
   assign events[uivt_pkg::SRC_ISO4] = ISO_FOUR_PID_SEQ_IRQ;
   // (RULE14) ISO six PID error
   assign events[uivt_pkg::SRC_ISO6] = ISO_SIX_PID_SEQ_IRQ;

   // Acknowledge clears the source now presented
   wire ack_take = VECTOR_ACK && valid_q;
   wire [16:0] ack_clr = ack_take ? (17'h00001 << idx_q) : 17'h00000;
   wire [16:0] w1c_clr = {wr_status_hi && WDATA[0],
      wr_status ? WDATA : 16'h0000};

   // (RULE17) Sticky until cleared, set beats clear
   assign status_d = (status_q & ~(w1c_clr | ack_clr)) | events;

   // (RULE16) Only unmasked pending bits compete
   assign sel.pending = status_q & mask_q;

   // (RULE11) Table holds no reserved offsets
   wire [7:0] vec_next = sel.found ?
      uivt_pkg::vector_of(sel.index) : uivt_pkg::VEC_IDLE;

   // Read selection; unmapped reads zero
   wire [15:0] rd_mux =
      hit_status ? status_q[15:0] :
      hit_mask ? mask_q[15:0] :
      hit_status_hi ? {15'h0000, status_q[16]} :
      hit_mask_hi ? {15'h0000, mask_q[16]} :
      hit_vector ? {7'h00, valid_q, vec_q} :
      hit_limit ? {8'h00, err_limit_q} :
      hit_count ? {8'h00, err_cnt_q} : 16'h0000;

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         status_q <= uivt_pkg::STATUS_RST;
         mask_q <= uivt_pkg::MASK_RST;
      end else if (CLK_EN) begin
         status_q <= status_d;
         if (wr_mask) begin
            mask_q[15:0] <= WDATA;
         end
         if (wr_mask_hi) begin
            mask_q[16] <= WDATA[0];
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         err_limit_q <= uivt_pkg::ERR_LIMIT_RST;
         err_cnt_q <= uivt_pkg::ERR_COUNT_RST;
      end else if (CLK_EN) begin
         err_cnt_q <= err_cnt_d;
         if (wr_limit) begin
            err_limit_q <= WDATA[7:0];
         end
      end
   end

   // (RULE16) Winning vector registered for the core
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         vec_q <= uivt_pkg::VEC_IDLE;
         idx_q <= uivt_pkg::SRC_IDX_RST;
         valid_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (CLK_EN) begin
         vec_q <= vec_next;
         idx_q <= sel.index;
         valid_q <= sel.found;
         irq_q <= sel.found;
      end
   end

   // Read data stands after the strobe only until the next clock edge with CLK_EN high
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         rdata_q <= 16'h0000;
      end else if (CLK_EN) begin
         rdata_q <= RD_STB ? rd_mux : 16'h0000;
      end
   end

   assign RDATA = rdata_q;
   assign IRQ = irq_q;
   assign VECTOR_VALID = valid_q;
   assign IRQ_VECTOR = vec_q;

endmodule
`default_nettype wire

// *** testbench/uivt_top_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module uivt_top_asserts (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   input wire logic [3:0] ADDR,
   input wire logic WR_STB,
   input wire logic RD_STB,
   input wire logic [15:0] RDATA,
   input wire logic VECTOR_ACK,
   input wire logic IRQ,
   input wire logic VECTOR_VALID,
   input wire logic [7:0] IRQ_VECTOR
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   sequence ack_s;
      VECTOR_ACK && VECTOR_VALID && CLK_EN && !WR_STB;
   endsequence
   rst_clear_a: assert property (disable iff (1'b0) !RST_N |=> !IRQ &&
      !VECTOR_VALID && RDATA == 16'h0000 && IRQ_VECTOR == 8'h00)
      else $error("outputs not cleared by reset");
   vec_valid_a: assert property (IRQ == VECTOR_VALID)
      else $error("irq and valid disagree");
   vec_idle_a: assert property (!VECTOR_VALID |-> IRQ_VECTOR == 8'h00)
      else $error("vector not zero while idle");
   vec_reserved_a: assert property (
      VECTOR_VALID |-> !(IRQ_VECTOR inside
      {8'h1C, 8'h44, 8'h64, 8'h68, 8'h6C}))
      else $error("reserved vector presented");
   vec_range_a: assert property (VECTOR_VALID |-> IRQ_VECTOR[1:0] == 2'b00
      && IRQ_VECTOR >= 8'h18 && IRQ_VECTOR <= 8'h78)
      else $error("vector outside table");
   ack_next_a: assert property (
      ack_s |-> ##2 IRQ_VECTOR != $past(IRQ_VECTOR, 2))
      else $error("vector kept after ack");
   rdata_idle_a: assert property (CLK_EN && !RD_STB |=> RDATA == 16'h0000)
      else $error("read data outside read slot");
   unmapped_zero_a: assert property (
      CLK_EN && RD_STB && ADDR > 4'h6 |=> RDATA == 16'h0000)
      else $error("unmapped read not zero");
endmodule
bind uivt_top uivt_top_asserts u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
   .CLK_EN(CLK_EN), .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB),
   .RDATA(RDATA), .VECTOR_ACK(VECTOR_ACK), .IRQ(IRQ),
   .VECTOR_VALID(VECTOR_VALID), .IRQ_VECTOR(IRQ_VECTOR));
`default_nettype wire

// *** testbench/uivt_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module uivt_core_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ack_en,
   input wire logic vector_valid,
   input wire logic [7:0] irq_vector,
   output logic vector_ack,
   output logic took,
   output logic [7:0] got_vec
);
   logic [7:0] wait_q;
   // Slow core: waits, acks once, lets next winner settle
   always @(posedge clk) begin
      took <= rst_n && vector_ack && vector_valid;
      if (!rst_n) begin
         vector_ack <= 1'b0;
         wait_q <= 8'h00;
      end else if (vector_ack) begin
         vector_ack <= 1'b0;
         got_vec <= irq_vector;
         wait_q <= 8'h00;
      end else if (vector_valid && ack_en && wait_q > 8'h02) begin
         vector_ack <= 1'b1;
      end else if (vector_valid) begin
         wait_q <= wait_q + 8'h01;
      end
   end
endmodule
`default_nettype wire

// *** testbench/tb_usb_interrupt_vector_table.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_usb_interrupt_vector_table;
   logic clk, rst_n, clk_en, wr_stb, rd_stb, bus_error, vector_ack, ack_en;
   logic irq, vector_valid, took;
   logic [3:0] addr;
   logic [15:0] wdata, rdata;
   logic [16:0] ev;
   logic [7:0] irq_vector, got_vec;
   logic [7:0] exp_vec [17];
   logic [7:0] got_q [$];
   int err_total, n_tests;
   uivt_top u_dut (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en),
      .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
      .RDATA(rdata), .CTRL_HANDSHAKE_ACK_IRQ(ev[0]),
      .EP_ONE_OUT_DATA_IRQ(ev[1]), .EP_TWO_BUF_IRQ(ev[2]),
      .EP_FOUR_BUF_IRQ(ev[3]), .EP_SIX_BUF_IRQ(ev[4]),
      .EP_EIGHT_BUF_IRQ(ev[5]), .BULK_IN_NAK_IRQ(ev[6]),
      .CTRL_OUT_PING_NAK_IRQ(ev[7]), .EP_ONE_OUT_PING_NAK_IRQ(ev[8]),
      .EP_TWO_OUT_PING_NAK_IRQ(ev[9]), .EP_FOUR_OUT_PING_NAK_IRQ(ev[10]),
      .EP_SIX_OUT_PING_NAK_IRQ(ev[11]), .EP_EIGHT_OUT_PING_NAK_IRQ(ev[12]),
      .BUS_ERROR(bus_error), .ISO_TWO_PID_SEQ_IRQ(ev[14]),
      .ISO_FOUR_PID_SEQ_IRQ(ev[15]), .ISO_SIX_PID_SEQ_IRQ(ev[16]),
      .VECTOR_ACK(vector_ack), .IRQ(irq), .VECTOR_VALID(vector_valid),
      .IRQ_VECTOR(irq_vector));
   uivt_core_model u_core (.clk(clk), .rst_n(rst_n), .ack_en(ack_en),
      .vector_valid(vector_valid), .irq_vector(irq_vector),
      .vector_ack(vector_ack), .took(took), .got_vec(got_vec));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) if (took) got_q.push_back(got_vec);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic pulse(input logic [16:0] m, input logic be, input int n);
      @(posedge clk);
      ev <= m;
      bus_error <= be;
      @(posedge clk);
      ev <= 17'h00000;
      bus_error <= 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #(25 * 5000);
      err_total++;
      wrap_up();
   end
   initial begin
      {rst_n, wr_stb, rd_stb, bus_error, ack_en} = 5'h00;
      clk_en = 1'b1;
      {addr, wdata, ev} = '0;
      {err_total, n_tests} = '0;
      exp_vec = '{8'h18, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h48,
         8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h60, 8'h70, 8'h74, 8'h78};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(uivt_pkg::REG_MASK, 16'h0000);
      rd(uivt_pkg::REG_ERR_LIMIT, 16'h0004);
      rd(4'hF, 16'h0000);
      wr(uivt_pkg::REG_MASK, 16'hFFFF);
      wr(uivt_pkg::REG_MASK_HI, 16'h0001);
      rd(uivt_pkg::REG_MASK_HI, 16'h0001);
      for (int i = 0; i < 17; i++) begin
         if (i == 13) continue;
         pulse(17'h1 << i, 1'b0, 1);
         chk({8'h00, irq_vector}, {8'h00, exp_vec[i]});
         chk(16'(vector_valid), 16'h0001);
         wr(uivt_pkg::REG_STATUS, 16'hFFFF);
         wr(uivt_pkg::REG_STATUS_HI, 16'h0001);
         @(posedge clk);
         #1 chk(16'(irq), 16'h0000);
      end
      wr(uivt_pkg::REG_ERR_LIMIT, 16'h0002);
      repeat (2) pulse(17'h00000, 1'b1, 2);
      chk(16'(irq), 16'h0000);
      pulse(17'h00000, 1'b1, 2);
      chk({8'h00, irq_vector}, 16'h0060);
      rd(uivt_pkg::REG_ERR_COUNT, 16'h0003);
      wr(uivt_pkg::REG_ERR_COUNT, 16'h0000);
      wr(uivt_pkg::REG_STATUS, 16'hFFFF);
      // Clock enable low: an event is dropped
      repeat (2) @(posedge clk);
      clk_en <= 1'b0;
      pulse(17'h00004, 1'b0, 1);
      chk(16'(irq), 16'h0000);
      clk_en <= 1'b1;
      wr(uivt_pkg::REG_MASK, 16'h0000);
      pulse(17'h00209, 1'b0, 1);
      chk(16'(irq), 16'h0000);
      rd(uivt_pkg::REG_STATUS, 16'h0209);
      wr(uivt_pkg::REG_MASK, 16'hFFFE);
      @(posedge clk);
      #1 chk({8'h00, irq_vector}, 16'h0034);
      wr(uivt_pkg::REG_MASK, 16'hFFFF);
      @(posedge clk);
      #1 chk({8'h00, irq_vector}, 16'h0018);
      ack_en <= 1'b1;
      for (int k = 0; k < 200 && got_q.size() < 3; k++) @(posedge clk);
      ack_en <= 1'b0;
      chk(16'(got_q.size()), 16'h0003);
      chk({got_q[0], got_q[1]}, 16'h1834);
      chk({8'h00, got_q[2]}, 16'h0050);
      rd(uivt_pkg::REG_STATUS, 16'h0000);
      wrap_up();
   end
endmodule
`default_nettype wire
